// >>> turbo_enc_map.svh
// Purpose: Named constants of the turbo encoder: block sizes, size segments and cycle counts.
// Assumes: Included by the package only.
// Notes: Definitions only.
`ifndef TURBO_ENC_MAP_SVH
`define TURBO_ENC_MAP_SVH
// ----------------------------------------------------------------
// Block size range and widths
// ----------------------------------------------------------------
`define TE_KMAX 13'h1800
`define TE_KW 13
`define TE_NSIZES 188
// ----------------------------------------------------------------
// Size table segments: lowest size, last size, first index, step shift
// ----------------------------------------------------------------
`define TE_BASE1 13'h0028
`define TE_END1 13'h0200
`define TE_SH1 3
`define TE_BASE2 13'h0210
`define TE_END2 13'h0400
`define TE_IDX2 8'h3C
`define TE_SH2 4
`define TE_BASE3 13'h0420
`define TE_END3 13'h0800
`define TE_IDX3 8'h5C
`define TE_SH3 5
`define TE_BASE4 13'h0840
`define TE_IDX4 8'h7C
`define TE_SH4 6
// ----------------------------------------------------------------
// Timing: setup cycles plus K data words plus tail words give K + 14
// ----------------------------------------------------------------
`define TE_PRE_CYC 4'hA
`define TE_TAIL_LAST 2'h3
`define TE_OB_DEPTH 2'h2
`endif

// >>> turbo_enc_pkg.sv
// Purpose: Types shared by the turbo encoder.
// Assumes: turbo_enc_map.svh holds the numbers.
// Notes: The module state apart from the bit banks is one packed struct.
`include "turbo_enc_map.svh"
package turbo_enc_pkg;
   typedef logic [`TE_KW-1:0] ksize_t;
   typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_DATA, ST_TAIL} enc_state_t;
   typedef struct packed {
      enc_state_t st;
      logic ld_bank;
      ksize_t ld_cnt;
      ksize_t ld_k;
      logic [1:0] full;
      logic [1:0][`TE_KW-1:0] ksz;
      logic rd_bank;
      logic [3:0] pre;
      ksize_t i;
      ksize_t k;
      ksize_t pi;
      ksize_t g;
      ksize_t d2;
      logic [2:0] s1;
      logic [2:0] s2;
      logic [11:0] tail;
      logic [1:0] tw;
      logic [1:0][4:0] ob;
      logic [1:0] ocnt;
   } enc_regs_t;
endpackage : turbo_enc_pkg

// >>> lte_turbo_encoder.sv
// Purpose: Rate 1/3 turbo encoder with quadratic permutation interleaver and trellis termination.
// Assumes: One clock; source and sink are logic on that clock with valid/ready streams.
// Notes: Two input banks let a block load while the previous one encodes.
`timescale 1ns/1ns
// Summary of operation
// - Two 8-state encoders plus one interleaver
// - Only rate one-third output is produced
// - Block size chosen per block at run time
// - Parity uses g1 over g0 polynomials
// - Both shift registers cleared before each block
// - Emit systematic, parity one, parity two per bit
// - Input bit feeds encoder one and interleaver
// - Tail bits taken from shift register feedback
// - Terminate first encoder, then the second
// - Twelve tail bits ordered as pairs per step
// - Interleaver reads index f1*i+f2*i*i mod K
// - f1, f2 from 188-entry block size table
// - Next block loads while current one encodes
// - Output word is three bits, one triple
// - Encoding takes K plus fourteen cycles
// - Loading a block takes K cycles
module lte_turbo_encoder (
   input wire logic clk, // 50 MHz system clock.
   input wire logic rst_b, // Synchronous reset, active low.
   input wire logic in_valid, // Information bit is present.
   output logic in_ready, // Encoder takes the bit this cycle.
   input wire logic in_bit, // Information bit.
   input wire logic in_sop, // First bit of a block.
   input wire logic in_eop, // Last bit of a block, informative only.
   input wire turbo_enc_pkg::ksize_t in_size, // Block size K, read with in_sop.
   output logic out_valid, // Coded word is present.
   input wire logic out_ready, // Sink takes the word this cycle.
   output logic [2:0] out_data, // Coded triple.
   output logic out_sop, // First word of a block.
   output logic out_eop // Last word of a block.
);
   import turbo_enc_pkg::*;

   // ----------------------------------------------------------------
   // Data flow
   // ----------------------------------------------------------------
   // The source writes one bit per accepted transfer into the bank that is being loaded.
   // When the K-th bit lands, that bank is marked full and loading moves to the other bank.
   // The sequencer picks up a full bank, looks up f1 and f2 for its size, and clears
   // both constituent registers before the first information bit.
   // Every data cycle reads two bits of the same bank: the natural bit at index i for the
   // first encoder and the permuted bit at index pi for the second encoder.
   // The permuted index is walked by two running sums instead of a multiplier, so the
   // interleaver costs two adders and no squaring logic at any block size.
   // Six termination steps are worked out in one go from the register contents after the
   // last information bit, then leave as four tail words.
   // The bank is freed only after its last tail word has entered the output buffer, so a
   // third block waits on in_ready instead of overwriting a bank that is still being read.
   // The output buffer holds two words; a stall by the sink fills it and then freezes the
   // sequencer, so nothing is lost and nothing is repeated.
   // Limitation: block sizes outside the standard table are not detected; they give an
   // undefined permutation and a block that is still framed as K plus four words.

   // ----------------------------------------------------------------
   // Interleaver parameters, packed as f1 in the upper and f2 in the lower 12 bits
   // ----------------------------------------------------------------
   localparam logic [23:0] PARAM_TBL [0:`TE_NSIZES-1] = '{
      24'h00300A, 24'h00700C, 24'h01302A, 24'h007010, 24'h007012, 24'h00B014, 24'h005016, 24'h00B018,
      24'h00701A, 24'h029054, 24'h06705A, 24'h00F020, 24'h009022, 24'h01106C, 24'h009026, 24'h015078,
      24'h065054, 24'h01502C, 24'h03902E, 24'h017030, 24'h00D032, 24'h01B034, 24'h00B024, 24'h01B038,
      24'h05503A, 24'h01D03C, 24'h02103E, 24'h00F020, 24'h0110C6, 24'h021044, 24'h0670D2, 24'h013024,
      24'h01304A, 24'h02504C, 24'h01304E, 24'h015078, 24'h015052, 24'h073054, 24'h0C1056, 24'h01502C,
      24'h08505A, 24'h05102E, 24'h02D05E, 24'h017030, 24'h0F3062, 24'h097028, 24'h09B066, 24'h019034,
      24'h03306A, 24'h02F048, 24'h05B06E, 24'h01D0A8, 24'h01D072, 24'h0F703A, 24'h01D076, 24'h0590B4,
      24'h05B07A, 24'h09D03E, 24'h037054, 24'h01F040, 24'h011042, 24'h023044, 24'h0E31A4, 24'h041060,
      24'h01304A, 24'h02504C, 24'h0290EA, 24'h027050, 24'h0B9052, 24'h02B0FC, 24'h015056, 24'h09B02C,
      24'h04F078, 24'h08B05C, 24'h01705E, 24'h0D9030, 24'h019062, 24'h011050, 24'h07F066, 24'h019034,
      24'h0EF06A, 24'h011030, 24'h08906E, 24'h0D7070, 24'h01D072, 24'h00F03A, 24'h093076, 24'h01D03C,
      24'h03B07A, 24'h04107C, 24'h037054, 24'h01F040, 24'h011042, 24'h0AB0CC, 24'h04308C, 24'h023048,
      24'h01304A, 24'h02704C, 24'h01304E, 24'h0C70F0, 24'h015052, 24'h0D30FC, 24'h015056, 24'h02B058,
      24'h09503C, 24'h02D05C, 24'h03134E, 24'h047030, 24'h00D01C, 24'h011050, 24'h019066, 24'h0B7068,
      24'h0373BA, 24'h07F060, 24'h01B06E, 24'h01D070, 24'h01D072, 24'h039074, 24'h02D162, 24'h01F078,
      24'h03B262, 24'h0B907C, 24'h0711A4, 24'h01F040, 24'h011042, 24'h0AB088, 24'h0D11A4, 24'h0FD0D8,
      24'h16F1BC, 24'h1091C8, 24'h0B51D4, 24'h027050, 24'h01B0A4, 24'h07F1F8, 24'h08F0AC, 24'h02B058,
      24'h01D12C, 24'h02D05C, 24'h09D0BC, 24'h02F060, 24'h00D01C, 24'h06F0F0, 24'h1BB0CC, 24'h033068,
      24'h0330D4, 24'h1C30C0, 24'h1010DC, 24'h039150, 24'h1390E4, 24'h10F0E8, 24'h0B30EC, 24'h14B078,
      24'h16B0F4, 24'h1770F8, 24'h07F0A8, 24'h01F040, 24'h021082, 24'h02B108, 24'h021086, 24'h1DD198,
      24'h02308A, 24'h0E9118, 24'h16508E, 24'h1511E0, 24'h025092, 24'h0471BC, 24'h047078, 24'h025098,
      24'h0271CE, 24'h07F0EA, 24'h02709E, 24'h027050, 24'h01F060, 24'h071386, 24'h0290A6, 24'h0FB150,
      24'h02B0AA, 24'h015056, 24'h02B0AE, 24'h02D0B0, 24'h02D0B2, 24'h0A1078, 24'h0590B6, 24'h1430B8,
      24'h02F0BA, 24'h01705E, 24'h02F0BE, 24'h1071E0
   };

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   // Maps a block size to its table row; sizes outside the table give an undefined permutation.
   // The table is four runs of evenly spaced sizes, so a subtract and a shift find the row
   // without a search; each run starts at its own first row.
   function automatic logic [7:0] size_index(input ksize_t k);
      ksize_t t;
      t = '0;
      if (k <= `TE_END1) begin
         t = (k - `TE_BASE1) >> `TE_SH1;
         return t[7:0];
      end else if (k <= `TE_END2) begin
         t = (k - `TE_BASE2) >> `TE_SH2;
         return t[7:0] + `TE_IDX2;
      end else if (k <= `TE_END3) begin
         t = (k - `TE_BASE3) >> `TE_SH3;
         return t[7:0] + `TE_IDX3;
      end
      t = (k - `TE_BASE4) >> `TE_SH4;
      return t[7:0] + `TE_IDX4;
   endfunction : size_index

   // Sum of two residues below k, reduced once; both operands must be below k.
   // One conditional subtract replaces a divider, which is why every running sum stays reduced.
   function automatic ksize_t add_mod(input ksize_t a, input ksize_t b, input ksize_t k);
      logic [`TE_KW:0] s;
      s = {1'b0, a} + {1'b0, b};
      if (s >= {1'b0, k}) begin
         s = s - {1'b0, k};
      end
      return s[`TE_KW-1:0];
   endfunction : add_mod

   // Three termination steps: input is the feedback, so the register fills with zeros.
   // Each step yields the systematic tail bit first and the parity tail bit second.
   function automatic logic [5:0] tail_bits(input logic [2:0] s);
      logic [2:0] r;
      logic [5:0] t;
      r = s;
      t = '0;
      for (int j = 0; j < 3; j++) begin
         t[2*j] = r[1] ^ r[2];
         t[2*j+1] = r[0] ^ r[2];
         r = {r[1], r[0], 1'b0};
      end
      return t;
   endfunction : tail_bits

   // ----------------------------------------------------------------
   // State, input banks and combinational next state
   // ----------------------------------------------------------------
   enc_regs_t q;
   enc_regs_t d;
   logic mem [0:1][0:`TE_KMAX-1];
   logic wr_en;
   ksize_t wr_addr;
   logic [23:0] prm;
   ksize_t f1;
   ksize_t f2;
   logic u;
   logic ui;
   logic a1;
   logic a2;
   logic z1;
   logic z2;
   logic [2:0] s1n;
   logic [2:0] s2n;
   logic pop;
   logic push;
   logic push_ok;
   logic [4:0] push_w;
   logic [1:0] cnt_p;
   ksize_t ld_k;

   // Handshake outputs are combinational; the word itself comes from the buffer flops.
   assign in_ready = !q.full[q.ld_bank];
   assign out_valid = (q.ocnt != 2'h0);
   assign out_data = q.ob[0][2:0];
   assign out_sop = q.ob[0][3];
   assign out_eop = q.ob[0][4];

   // Table lookup and constituent encoder arithmetic for the current index.
   always_comb begin
      prm = PARAM_TBL[size_index(q.k)];
      // The two fields are 12 bits each; the spare top bit of the index width is zero.
      f1 = {1'b0, prm[23:12]};
      f2 = {1'b0, prm[11:0]};
      u = mem[q.rd_bank][q.i];
      ui = mem[q.rd_bank][q.pi];
      a1 = u ^ q.s1[1] ^ q.s1[2];
      z1 = a1 ^ q.s1[0] ^ q.s1[2];
      a2 = ui ^ q.s2[1] ^ q.s2[2];
      z2 = a2 ^ q.s2[0] ^ q.s2[2];
      s1n = {q.s1[1], q.s1[0], a1};
      s2n = {q.s2[1], q.s2[0], a2};
   end

   // Loader, encoder sequencer and two-entry output buffer.
   always_comb begin
      d = q;
      wr_en = 1'b0;
      wr_addr = in_sop ? '0 : q.ld_cnt;
      ld_k = in_sop ? in_size : q.ld_k;
      push = 1'b0;
      push_w = '0;
      pop = out_valid && out_ready;
      cnt_p = q.ocnt - {1'b0, pop};
      push_ok = (cnt_p != `TE_OB_DEPTH);
      // A start marker restarts the block, so a cut-short block is simply overwritten.
      if (in_valid && in_ready) begin
         wr_en = 1'b1;
         d.ld_k = ld_k;
         if (wr_addr == ld_k - 1'b1) begin
            d.full[q.ld_bank] = 1'b1;
            d.ksz[q.ld_bank] = ld_k;
            d.ld_bank = !q.ld_bank;
            d.ld_cnt = '0;
         end else begin
            d.ld_cnt = wr_addr + 1'b1;
         end
      end
      case (q.st)
         ST_IDLE: begin
            if (q.full[q.rd_bank]) begin
               d.k = q.ksz[q.rd_bank];
               d.pre = '0;
               d.st = ST_SETUP;
            end
         end
         // Fixed setup time keeps the block time at K + 14 whatever the size.
         // The lookup result is only used here, so its path may settle over several cycles.
         // The increments are set up from f1 and f2 so that index 0 maps to itself and the
         // first step of the running sum already equals f1 + f2.
         ST_SETUP: begin
            d.s1 = '0;
            d.s2 = '0;
            d.i = '0;
            d.pi = '0;
            d.g = add_mod(f1, f2, q.k);
            d.d2 = add_mod(f2, f2, q.k);
            d.pre = q.pre + 1'b1;
            if (q.pre == `TE_PRE_CYC - 1'b1) begin
               d.st = ST_DATA;
            end
         end
         ST_DATA: begin
            if (push_ok) begin
               push = 1'b1;
               push_w = {1'b0, (q.i == '0), z2, z1, u};
               d.s1 = s1n;
               d.s2 = s2n;
               d.i = q.i + 1'b1;
               d.pi = add_mod(q.pi, q.g, q.k);
               d.g = add_mod(q.g, q.d2, q.k);
               if (q.i == q.k - 1'b1) begin
                  d.tail = {tail_bits(s2n), tail_bits(s1n)};
                  d.tw = '0;
                  d.st = ST_TAIL;
               end
            end
         end
         ST_TAIL: begin
            if (push_ok) begin
               push = 1'b1;
               push_w = {(q.tw == `TE_TAIL_LAST), 1'b0, q.tail[q.tw*3 +: 3]};
               d.tw = q.tw + 1'b1;
               if (q.tw == `TE_TAIL_LAST) begin
                  d.full[q.rd_bank] = 1'b0;
                  d.rd_bank = !q.rd_bank;
                  d.st = ST_IDLE;
               end
            end
         end
         default: begin
            d.st = ST_IDLE;
         end
      endcase
      // A stalled sink fills the buffer, which then holds the encoder in place.
      if (pop) begin
         d.ob[0] = q.ob[1];
      end
      if (push) begin
         d.ob[cnt_p[0]] = push_w;
      end
      d.ocnt = cnt_p + {1'b0, push};
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // The state register; reset leaves both banks empty and the buffer drained.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Bit banks are not reset; a bank is only read after it has been filled.
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[q.ld_bank][wr_addr] <= in_bit;
      end
   end
endmodule : lte_turbo_encoder

// >>> lte_turbo_encoder_monitor.sv
// Purpose: Framing and timing checks on the turbo encoder stream ports.
// Assumes: Bound to lte_turbo_encoder; one clock, synchronous active-low reset.
// Notes: A four-deep ring of sizes covers two banks and a block still draining.
`timescale 1ns/1ns
module lte_turbo_encoder_monitor (
   input wire logic clk, // Clock.
   input wire logic rst_b, // Reset.
   input wire logic in_valid, // Bit offered.
   input wire logic in_ready, // Bit free.
   input wire logic in_bit, // Bit.
   input wire logic in_sop, // Start.
   input wire logic in_eop, // End.
   input wire turbo_enc_pkg::ksize_t in_size, // Size.
   input wire logic out_valid, // Word offered.
   input wire logic out_ready, // Word taken.
   input wire logic [2:0] out_data, // Word.
   input wire logic out_sop, // First word.
   input wire logic out_eop // Last word.
);
   import turbo_enc_pkg::*;
   // ----------------------------------------
   // Block tracking
   // ----------------------------------------
   ksize_t ks_q [4];
   ksize_t ld_q, wc_q;
   logic [1:0] nl_q, no_q;
   logic in_tk, out_tk, ld_done;
   assign in_tk = in_valid && in_ready;
   assign out_tk = out_valid && out_ready;
   assign ld_done = in_tk && !in_sop && ld_q == ks_q[nl_q] - 13'h0001;
   // Counters follow accepted traffic only, so refused offers never shift the ring.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ld_q <= 13'h0000;
         wc_q <= 13'h0000;
         nl_q <= 2'h0;
         no_q <= 2'h0;
      end else begin
         if (in_tk && in_sop) ks_q[nl_q] <= in_size;
         if (in_tk) ld_q <= in_sop ? 13'h0001 : ld_q + 13'h0001;
         if (ld_done) nl_q <= nl_q + 2'h1;
         if (out_tk) wc_q <= out_eop ? 13'h0000 : wc_q + 13'h0001;
         if (out_tk && out_eop) no_q <= no_q + 2'h1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_mid_take;
      out_tk && !out_eop;
   endsequence
   sequence s_idle_load;
      ld_done && nl_q == no_q && !out_valid;
   endsequence
   a_reset_clear: assert property (disable iff (1'b0) !rst_b |=> in_ready && !out_valid)
      else $error("outputs not idle after reset");
   a_stall_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data)
      && $stable(out_sop) && $stable(out_eop)) else $error("word changed while stalled");
   a_sop_first: assert property (out_valid && out_sop |-> wc_q == 13'h0000)
      else $error("start marker not on first word");
   a_eop_count: assert property (out_tk && out_eop |-> wc_q == ks_q[no_q] + 13'h0003)
      else $error("block not K plus four words");
   a_marks_apart: assert property (out_valid |-> !(out_sop && out_eop))
      else $error("start and end marker together");
   a_word_flow: assert property (s_mid_take ##1 out_ready |-> out_valid)
      else $error("gap inside a block");
   a_first_word: assert property (s_idle_load |-> !out_valid [*8] ##[4:6] (out_valid && out_sop))
      else $error("first word latency wrong");
   a_bank_free: assert property (2'(nl_q - no_q) < 2'h2 |-> in_ready)
      else $error("input refused with a free bank");
endmodule : lte_turbo_encoder_monitor
bind lte_turbo_encoder lte_turbo_encoder_monitor i_mon (.clk(clk), .rst_b(rst_b), .in_valid(in_valid),
   .in_ready(in_ready), .in_bit(in_bit), .in_sop(in_sop), .in_eop(in_eop), .in_size(in_size),
   .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_sop(out_sop), .out_eop(out_eop));

// >>> te_sink.sv
// Purpose: Downstream rate-matching stand-in that takes coded words.
// Assumes: Ready moves 1 ns after the edge.
// Notes: Stall chance is set by the bench; 100 refuses everything.
`timescale 1ns/1ns
module te_sink (
   input wire logic clk, // Clock.
   input wire logic out_valid, // Word offered.
   input wire logic [2:0] out_data, // Word.
   input wire logic out_sop, // First word.
   input wire logic out_eop, // Last word.
   input wire logic [6:0] stall, // Stall percent.
   output logic out_ready // Accept.
);
   logic [4:0] q [$];
   initial out_ready = 1'b0;
   // A word counts only at an edge where ready already stood high.
   always @(posedge clk) begin
      if (out_valid && out_ready) q.push_back({out_sop, out_eop, out_data});
      #1 out_ready = ($urandom_range(99) >= stall);
   end
endmodule : te_sink

// >>> tb.sv
// Purpose: Random and corner blocks through the turbo encoder against a reference model.
// Assumes: te_sink takes the words; the checker is bound.
// Notes: Sizes touch every segment of the size table.
`timescale 1ns/1ns
module tb;
   import turbo_enc_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic in_valid = 1'b0;
   logic in_bit = 1'b0;
   logic in_sop = 1'b0;
   logic in_eop = 1'b0;
   ksize_t in_size = 13'h0000;
   logic [6:0] stall = 7'h00;
   logic in_ready, out_valid, out_ready, out_sop, out_eop;
   logic [2:0] out_data;
   logic [4:0] exp_q [$];
   int fails = 0;
   int tests_run = 0;
   int kt [8] = '{40, 48, 56, 512, 528, 1024, 2048, 6144};
   int f1t [8] = '{3, 7, 19, 31, 17, 31, 31, 263};
   int f2t [8] = '{10, 12, 42, 64, 66, 64, 64, 480};
   always #10 clk = ~clk;
   lte_turbo_encoder i_dut (.clk(clk), .rst_b(rst_b), .in_valid(in_valid), .in_ready(in_ready),
      .in_bit(in_bit), .in_sop(in_sop), .in_eop(in_eop), .in_size(in_size), .out_valid(out_valid),
      .out_ready(out_ready), .out_data(out_data), .out_sop(out_sop), .out_eop(out_eop));
   te_sink i_sink (.clk(clk), .out_valid(out_valid), .out_data(out_data), .out_sop(out_sop),
      .out_eop(out_eop), .stall(stall), .out_ready(out_ready));
   // ----------------------------------------
   // Reference model and checks
   // ----------------------------------------
   // One constituent step; in the tail the input is the feedback itself, so zeros enter the register.
   function automatic bit [1:0] rsc(inout bit [2:0] s, input bit x, input bit tail);
      bit fb;
      bit a;
      fb = s[1] ^ s[2];
      if (tail) x = fb;
      a = x ^ fb;
      rsc = {x, a ^ s[0] ^ s[2]};
      s = {s[1:0], a};
   endfunction : rsc
   function automatic void expect_block(input bit x [], input int k, input int f1, input int f2);
      bit [2:0] s1 = 3'h0;
      bit [2:0] s2 = 3'h0;
      bit [1:0] r1, r2;
      bit t [$];
      longint p;
      for (int i = 0; i < k; i++) begin
         p = (longint'(f1) * i + longint'(f2) * i * i) % k;
         r1 = rsc(s1, x[i], 1'b0);
         r2 = rsc(s2, x[p], 1'b0);
         exp_q.push_back({i == 0, 1'b0, r2[0], r1[0], x[i]});
      end
      for (int j = 0; j < 6; j++) begin
         if (j < 3) r1 = rsc(s1, 1'b0, 1'b1);
         else r1 = rsc(s2, 1'b0, 1'b1);
         t.push_back(r1[1]);
         t.push_back(r1[0]);
      end
      for (int j = 0; j < 4; j++) exp_q.push_back({1'b0, j == 3, t[3*j+2], t[3*j+1], t[3*j]});
   endfunction : expect_block
   task automatic chk(input logic [4:0] got, input logic [4:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic close_out;
      $display("Compared %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : close_out
   // Sends table entry n; gaps drop valid now and then to test stretched loads.
   task automatic send(input int n, input bit gaps);
      bit x [];
      int w;
      x = new[kt[n]];
      foreach (x[i]) x[i] = 1'($urandom_range(1));
      expect_block(x, kt[n], f1t[n], f2t[n]);
      in_size = ksize_t'(kt[n]);
      foreach (x[i]) begin
         in_valid = 1'b1;
         in_bit = x[i];
         in_sop = (i == 0);
         in_eop = (i == kt[n] - 1);
         for (w = 0; !in_ready && w < 30000; w++) @(posedge clk) #1;
         if (w == 30000) begin
            fails++;
            close_out;
         end
         @(posedge clk) #1;
         if (gaps && $urandom_range(3) == 0) begin
            in_valid = 1'b0;
            @(posedge clk) #1;
         end
      end
      // Let an edge pass so the next block never raises valid in the same time step.
      in_valid = 1'b0;
      @(posedge clk) #1;
   endtask : send
   initial begin
      int w;
      void'($urandom(32'hB478));
      repeat (3) @(posedge clk);
      #1 rst_b = 1'b1;
      // Both banks fill while the sink refuses all, so the input must close.
      stall = 7'h64;
      send(0, 1'b0);
      send(0, 1'b0);
      repeat (20) @(posedge clk);
      #1 chk({4'h0, in_ready}, 5'h00);
      stall = 7'h1E;
      for (int n = 1; n < 8; n++) send(n, n[0]);
      stall = 7'h00;
      send(2, 1'b0);
      for (int r = 0; r < 4; r++) begin
         stall = 7'($urandom_range(60));
         send($urandom_range(5), 1'b1);
      end
      for (w = 0; i_sink.q.size() < exp_q.size() && w < 50000; w++) @(posedge clk);
      chk({4'h0, i_sink.q.size() == exp_q.size()}, 5'h01);
      foreach (exp_q[j]) chk(i_sink.q[j], exp_q[j]);
      close_out;
   end
endmodule : tb
